/* File: tb/fcb_chk.sv */
`timescale 1ns/1ps
module fcb_chk #(parameter ACC_W=34) (
  input wire ref_clk,reset_n,reg_wr,reg_rd,fir_out_valid,sample_valid,
  input wire [11:0] reg_addr,
  input wire [23:0] reg_wdata,reg_rdata,
  input wire [ACC_W-1:0] fir_out);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence s_cwr; reg_wr&&reg_addr==12'h450; endsequence
  sequence s_crd; reg_rd&&reg_addr==12'h450; endsequence
  a_center_full: assert property (
    s_cwr ##1 s_crd |=> reg_rdata==$past(reg_wdata,2)) else $error("center");
  a_outer_top: assert property (
    reg_rd&&reg_addr!=12'h450 |=> reg_rdata[23:16]==0) else $error("top");
  a_tap8_msb: assert property (
    reg_rd&&reg_addr==12'h459 |=> !reg_rdata[11]) else $error("msb");
  a_hole_zero: assert property (
    reg_rd&&reg_addr==12'h451 |=> reg_rdata==0) else $error("hole");
  a_rd_idle: assert property (
    !$past(reg_rd) |-> reg_rdata==0) else $error("idle");
  a_reset_zero: assert property (
    !$past(reset_n) |-> reg_rdata==0&&fir_out==0) else $error("reset");
  a_out_cause: assert property (
    fir_out_valid |-> $past(sample_valid)) else $error("cause");
  a_out_hold: assert property (
    !fir_out_valid |-> $stable(fir_out)) else $error("hold");
endmodule // fcb_chk
bind fcb_bank fcb_chk #(.ACC_W(ACC_W)) u_chk(.ref_clk,.reset_n,.reg_wr,
  .reg_rd,.fir_out_valid,.sample_valid,.reg_addr,.reg_wdata,.reg_rdata,
  .fir_out);

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  reg ref_clk=0,reset_n=0,reg_wr=0,reg_rd=0,sample_valid=0;
  reg [11:0] reg_addr=0,sample_in=0;
  reg [23:0] reg_wdata=0;
  wire [23:0] reg_rdata;
  wire [33:0] fir_out;
  wire fir_out_valid;
  integer bad_count=0,n_tests=0,j;
  fcb_bank u_dut(.ref_clk,.reset_n,.reg_addr,.reg_wdata,.reg_wr,.reg_rd,
    .reg_rdata,.sample_in,.sample_valid,.fir_out,.fir_out_valid);
  initial forever #2.5 ref_clk=~ref_clk;
  // Address holes make the map irregular around the wide center tap
  function [11:0] adr(input integer k);
    adr=k<4?12'h448+2*k:k==4?12'h450:12'h449+2*k;
  endfunction
  task chk(input [34:0] got,exp);
    n_tests=n_tests+1;
    if (got!==exp)
    begin
      bad_count=bad_count+1;
      $display("wrong value at %0t: got %h exp %h",$time,got,exp);
    end
  endtask
  // Called just after an edge; returns 1 ns after one, so calls run gap-free
  task wr(input [11:0] a,input [23:0] d);
    {reg_wr,reg_addr,reg_wdata}<={1'b1,a,d};
    @(posedge ref_clk) reg_wr<=0;
    #1;
  endtask
  task rd(input [11:0] a,input [23:0] e);
    {reg_rd,reg_addr}<={1'b1,a};
    @(posedge ref_clk) reg_rd<=0;
    #1 chk(reg_rdata,e);
  endtask
  task t_regs;
    for (j=0;j<10;j=j+1) rd(adr(j),0);
    for (j=0;j<9;j=j+1) wr(adr(j),24'hFFFFFF);
    wr(12'h451,24'hFFFFFF);
    for (j=0;j<9;j=j+1)
      rd(adr(j),j==4?24'hFFFFFF:j==8?24'hF7FF:24'hFFFF);
    rd(12'h451,0);
    $display("register test done");
  endtask
  task t_fir;
    for (j=0;j<9;j=j+1) wr(adr(j),0);
    wr(12'h450,24'h000002);
    rd(12'h450,24'h000002);
    wr(12'h459,24'h000800);
    // Sample offered while single-channel must not enter the history
    @(posedge ref_clk) {sample_valid,sample_in}<={1'b1,12'h7FF};
    @(posedge ref_clk) sample_valid<=0;
    #1 chk(fir_out_valid,0);
    wr(12'h45B,24'h000001);
    for (j=0;j<11;j=j+1)
    begin
      @(posedge ref_clk) sample_valid<=j<10;
      sample_in<=j==0;
      #1 if (j>0) chk({fir_out_valid,fir_out},
        {1'b1,j==6?34'h2:j==10?34'h3FFFFF800:34'h0});
    end
    $display("filter test done");
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d",n_tests,bad_count);
    if (bad_count==0&&n_tests>0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge ref_clk);
    reset_n<=1;
    t_regs;
    t_fir;
    stop_test;
  end
endmodule // tb_top

/* File: verilog/fcb_bank.v */
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`include "fcb_regs.vh"

module fcb_bank #(
  parameter SAMPLE_W = 12,
  parameter ACC_W    = 34
) (
  input  wire                    ref_clk,       // 200 MHz clock
  input  wire                    reset_n,       // Synchronous reset, low
  input  wire [11:0]             reg_addr,      // Register address
  input  wire [23:0]             reg_wdata,     // Write data
  input  wire                    reg_wr,        // Write strobe
  input  wire                    reg_rd,        // Read strobe
  output reg  [23:0]             reg_rdata,     // Read data, cycle after
  input  wire [SAMPLE_W-1:0]     sample_in,     // Channel B sample
  input  wire                    sample_valid,  // Sample strobe
  output reg  [ACC_W-1:0]        fir_out,       // Filtered sample
  output reg                     fir_out_valid  // Filtered sample strobe
);

  reg  [23:0]          coef [0:`FCB_NUM_TAPS-1];
  reg  [SAMPLE_W-1:0]  smp  [0:`FCB_NUM_TAPS-1];
  reg                  dual_mode;
  reg  signed [ACC_W-1:0] next_acc;
  wire [3:0]           wr_tap;
  wire [3:0]           rd_tap;
  integer              i;
  integer              m;
  integer              n;

  function [3:0] fcb_decode;
    input [11:0] a;
    begin
      case (a)
        `FCB_ADDR_TAP0: fcb_decode = 4'h0; // RULE7
        `FCB_ADDR_TAP1: fcb_decode = 4'h1; // RULE7
        `FCB_ADDR_TAP2: fcb_decode = 4'h2; // RULE7
        `FCB_ADDR_TAP3: fcb_decode = 4'h3; // RULE3
        `FCB_ADDR_TAP4: fcb_decode = 4'h4; // RULE3
        `FCB_ADDR_TAP5: fcb_decode = 4'h5; // RULE3
        `FCB_ADDR_TAP6: fcb_decode = 4'h6; // RULE3
        `FCB_ADDR_TAP7: fcb_decode = 4'h7; // RULE3
        `FCB_ADDR_TAP8: fcb_decode = 4'h8; // RULE3
        default:        fcb_decode = `FCB_TAP_NONE;
      endcase
    end
  endfunction

  // Sign-extends either coefficient format to the 18-bit datapath width
  function signed [17:0] fcb_coef;
    input [3:0]  k;
    input [23:0] r;
    begin
      if (k == `FCB_TAP_CENTER)
        fcb_coef = $signed(r[`FCB_CENTER_MSB:0]); // RULE2
      else
        fcb_coef = {{6{r[`FCB_OUTER_MSB]}}, r[`FCB_OUTER_MSB:0]}; // RULE1
    end
  endfunction

  assign wr_tap = fcb_decode(reg_addr);
  assign rd_tap = fcb_decode(reg_addr);

  always @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      for (i = 0; i < `FCB_NUM_TAPS; i = i + 1)
        coef[i] <= `FCB_COEF_RESET; // RULE6
      dual_mode <= `FCB_CTRL_RESET;
    end
    else if (reg_wr)
    begin
      // Reserved bits 23:18 (center) and 15:12 (outer) are writable storage, unused by the filter
      if (wr_tap == `FCB_TAP_CENTER)
        coef[wr_tap] <= reg_wdata; // RULE2
      else if (wr_tap != `FCB_TAP_NONE)
        coef[wr_tap] <= {8'h00, reg_wdata[`FCB_OUTER_RMSB:0]}; // RULE1
      else if (reg_addr == `FCB_ADDR_CTRL)
        dual_mode <= reg_wdata[`FCB_CTRL_DUAL];
    end
  end

  always @(posedge ref_clk)
  begin
    if (!reset_n)
      reg_rdata <= `FCB_RD_ZERO;
    else if (reg_rd)
    begin
      if (rd_tap == `FCB_TAP_LAST)
        reg_rdata <= {12'h000, 1'b0, coef[rd_tap][`FCB_OUTER_MSB-1:0]} | // RULE5
                     {8'h00, coef[rd_tap][`FCB_OUTER_RMSB:`FCB_OUTER_MSB+1],
                      12'h000};
      else if (rd_tap != `FCB_TAP_NONE)
        reg_rdata <= coef[rd_tap];
      else if (reg_addr == `FCB_ADDR_CTRL)
        reg_rdata <= {23'h000000, dual_mode};
      else
        reg_rdata <= `FCB_RD_ZERO;
    end
    else
      reg_rdata <= `FCB_RD_ZERO;
  end

  // smp[0] is newest, so the center tap meets the fifth-newest sample
  always @*
  begin
    next_acc = {ACC_W{1'b0}};
    for (m = 0; m < `FCB_NUM_TAPS; m = m + 1)
      next_acc = next_acc + $signed(smp[m]) * fcb_coef(m[3:0], coef[m]); // RULE8
  end

  always @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      for (n = 0; n < `FCB_NUM_TAPS; n = n + 1)
        smp[n] <= {SAMPLE_W{1'b0}};
      fir_out       <= {ACC_W{1'b0}};
      fir_out_valid <= 1'b0;
    end
    else
    begin
      // Outside dual-channel mode the history freezes and no output flows
      fir_out_valid <= sample_valid & dual_mode; // RULE4
      if (sample_valid && dual_mode)
      begin
        smp[0] <= sample_in;
        for (n = 1; n < `FCB_NUM_TAPS; n = n + 1)
          smp[n] <= smp[n-1];
        fir_out <= next_acc; // RULE8
      end
    end
  end

endmodule // fcb_bank

/* File: verilog/fcb_regs.vh */
// Functional notes
// [RULE1] Outer tap registers keep a signed 12-bit coefficient in bits 11:0.
// [RULE2] Center tap keeps an 18-bit signed coefficient in bits 17:0 of 24.
// [RULE3] Six registers map in address order to taps four to nine.
// [RULE4] Channel B coefficients apply only while dual-channel mode is on.
// [RULE5] Ninth-tap readback shows coefficient MSB as zero; filter uses it.
// [RULE6] All coefficient registers reset to zero.
// [RULE7] Taps one to three sit at lower addresses, same 12-bit format.
// [RULE8] Output is sum of nine coefficients times nine newest samples.
`ifndef FCB_REGS_VH
`define FCB_REGS_VH

`define FCB_ADDR_TAP0    12'h448
`define FCB_ADDR_TAP1    12'h44A
`define FCB_ADDR_TAP2    12'h44C
`define FCB_ADDR_TAP3    12'h44E
`define FCB_ADDR_TAP4    12'h450
`define FCB_ADDR_TAP5    12'h453
`define FCB_ADDR_TAP6    12'h455
`define FCB_ADDR_TAP7    12'h457
`define FCB_ADDR_TAP8    12'h459
`define FCB_ADDR_CTRL    12'h45B

`define FCB_TAP_NONE     4'hF
`define FCB_TAP_CENTER   4'h4
`define FCB_TAP_LAST     4'h8
`define FCB_NUM_TAPS     9

`define FCB_OUTER_MSB    11
`define FCB_OUTER_RMSB   15
`define FCB_CENTER_MSB   17
`define FCB_CENTER_RMSB  23
`define FCB_CTRL_DUAL    0

`define FCB_COEF_RESET   24'h000000
`define FCB_CTRL_RESET   1'h0
`define FCB_RD_ZERO      24'h000000

`endif
